/* verilog/kwu_keypad_wake_unit.v */
/*
 * Keypad wake unit: APB register slave, pin event flag, interrupt
 * request, wake request for shallow stop and pull resistor steering.
 * Assumes a single 20 MHz pclk, APB master of 32-bit data, and a
 * power controller that drives the wait and stop mode inputs.
 */
`timescale 1ns/100ps
`include "kwu_regs.vh"
module kwu_keypad_wake_unit #(
    parameter NUM_PINS = 7
) (
    input  wire                   pclk,
    input  wire                   presetn,
    input  wire                   psel,
    input  wire                   penable,
    input  wire                   pwrite,
    input  wire [`KWU_ADDR_W-1:0] paddr,
    input  wire [31:0]            pwdata,
    output wire                   pready,
    output reg  [31:0]            prdata,
    output reg                    pslverr,
    input  wire [NUM_PINS-1:0]    wake_input_pin,
    input  wire [NUM_PINS-1:0]    port_pull_enable,
    input  wire                   wait_mode,
    input  wire                   shallow_stop,
    input  wire                   deep_stop,
    output wire                   irq,
    output wire                   wake_request,
    output wire [NUM_PINS-1:0]    pull_up_en,
    output wire [NUM_PINS-1:0]    pull_down_en
);

    // Registers
    reg        request_enable;
    reg        level_mode_select;
    reg        event_flag;
    reg [7:0]  pin_interrupt_enable;
    reg [7:0]  pin_interrupt_polarity;
    reg        edge_armed;

    wire [NUM_PINS-1:0] pin_sample;
    wire [NUM_PINS-1:0] pin_asserted;
    wire [NUM_PINS-1:0] pin_edge;

    wire setup_phase;
    wire wr_access;
    wire sel_ctrl;
    wire sel_enable;
    wire sel_polarity;
    wire addr_hit;
    wire ack_write;
    wire any_asserted;
    wire edge_valid;
    wire flag_set;
    wire flag_clear;
    wire [NUM_PINS-1:0] raw_asserted;

    reg  next_event_flag;
    reg  next_edge_armed;
    reg  [31:0] next_prdata;

    // Pin synchroniser
    kwu_sync #(
        .WIDTH    (NUM_PINS)
    ) u_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (wake_input_pin),
        .sync_out (pin_sample)
    );

    // Detection on synchronised samples; deep stop wipes history
    kwu_detect #(
        .WIDTH     (NUM_PINS)
    ) u_detect (
        .pclk      (pclk),
        .presetn   (presetn),
        .clear     (deep_stop),
        .sample    (pin_sample),
        .enable    (pin_interrupt_enable[NUM_PINS-1:0]),
        .polarity  (pin_interrupt_polarity[NUM_PINS-1:0]),
        .asserted  (pin_asserted),
        .edge_seen (pin_edge)
    );

    // APB decode; the slave never inserts wait states
    assign pready       = 1'b1;
    assign setup_phase  = psel & ~penable;
    assign wr_access    = psel & penable & pwrite;
    assign sel_ctrl     = (paddr == `KWU_OFF_CTRL);
    assign sel_enable   = (paddr == `KWU_OFF_ENABLE);
    assign sel_polarity = (paddr == `KWU_OFF_POLARITY);
    assign addr_hit     = sel_ctrl | sel_enable | sel_polarity;
    assign ack_write    = wr_access & sel_ctrl &
                          pwdata[`KWU_BIT_ACK];

    // Detection logic; debug mode has no say in it
    assign any_asserted = |pin_asserted;
    // An edge counts only while every enabled pin was at rest
    assign edge_valid   = edge_armed & (|pin_edge);
    assign flag_set     = edge_valid |
                          (level_mode_select & any_asserted);
    assign flag_clear   = ack_write &
                          (~level_mode_select |
                           ~any_asserted);

    always @* begin
        next_event_flag = event_flag;
        if (flag_set) begin
            next_event_flag = 1'b1;
        end else if (flag_clear) begin
            next_event_flag = 1'b0;
        end
    end

    always @* begin
        next_edge_armed = edge_armed;
        if (!any_asserted) begin
            next_edge_armed = 1'b1;
        end else if (edge_valid) begin
            next_edge_armed = 1'b0;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            request_enable         <= 1'b0;
            level_mode_select      <= 1'b0;
            event_flag             <= 1'b0;
            pin_interrupt_enable   <= `KWU_RST_ENABLE;
            pin_interrupt_polarity <= `KWU_RST_POLARITY;
            edge_armed             <= 1'b0;
        end else if (deep_stop) begin
            // Unit is off and comes back in its reset state
            request_enable         <= 1'b0;
            level_mode_select      <= 1'b0;
            event_flag             <= 1'b0;
            pin_interrupt_enable   <= `KWU_RST_ENABLE;
            pin_interrupt_polarity <= `KWU_RST_POLARITY;
            edge_armed             <= 1'b0;
        end else begin
            event_flag <= next_event_flag;
            edge_armed <= next_edge_armed;
            if (wr_access && sel_ctrl) begin
                request_enable    <= pwdata[`KWU_BIT_REQ_EN];
                level_mode_select <= pwdata[`KWU_BIT_LEVEL_MODE];
            end
            if (wr_access && sel_enable) begin
                pin_interrupt_enable <= pwdata[7:0];
            end
            if (wr_access && sel_polarity) begin
                pin_interrupt_polarity <= pwdata[7:0];
            end
        end
    end

    // Read data captured in the setup phase
    always @* begin
        next_prdata = 32'h00000000;
        if (sel_ctrl) begin
            next_prdata[`KWU_BIT_FLAG]       = event_flag;
            next_prdata[`KWU_BIT_REQ_EN]     = request_enable;
            next_prdata[`KWU_BIT_LEVEL_MODE] = level_mode_select;
            // Bits 7:4 and the acknowledge bit stay zero
        end else if (sel_enable) begin
            next_prdata[7:0] = pin_interrupt_enable;
        end else if (sel_polarity) begin
            next_prdata[7:0] = pin_interrupt_polarity;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end else if (setup_phase) begin
            prdata  <= pwrite ? 32'h00000000 : next_prdata;
            pslverr <= ~addr_hit;
        end
    end

    // Interrupt request works in run, wait and debug alike
    assign irq = event_flag & request_enable;

    // Clock may be stopped in shallow stop: detect on raw pins
    genvar i;
    generate
        for (i = 0; i < NUM_PINS; i = i + 1) begin : g_raw
            assign raw_asserted[i] = pin_interrupt_enable[i] &
                (pin_interrupt_polarity[i] ? wake_input_pin[i]
                                           : ~wake_input_pin[i]);
        end
    endgenerate

    assign wake_request = request_enable & ~deep_stop &
        ((shallow_stop & (|raw_asserted)) |
         ((wait_mode | shallow_stop) & event_flag));

    // Pull resistor direction follows polarity
    assign pull_up_en   = port_pull_enable &
                          ~pin_interrupt_polarity[NUM_PINS-1:0];
    assign pull_down_en = port_pull_enable &
                          pin_interrupt_polarity[NUM_PINS-1:0];

endmodule // kwu_keypad_wake_unit

/* verilog/kwu_regs.vh */
/*
 * Register offsets, field positions and reset values of the keypad
 * wake unit. Assumes a 32-bit APB slave with byte addresses; each
 * register sits in the low byte of one aligned word.
 */
// Operation
// - One unit; seven wake input pins, each enabled on its own.
// - Status/control bits 7 to 4 always read zero.
// - Bit 3 is the event flag; read only, writes ignored.
// - Bit 2 is write-one acknowledge; always reads zero.
// - Bit 1 request enable gates the interrupt request from the flag.
// - Bit 0 picks edge-only or edge-and-level detection.
// - Each enable bit makes its pin a source; disabled pins ignored.
// - Each polarity bit picks falling/low or rising/high sensitivity.
// - Falling edge: sampled high one cycle, low the next.
// - Rising edge: sampled low one cycle, high the next.
// - New edge only after all enabled inputs are deasserted.
// - Edge mode: valid edge sets flag; request if enabled.
// - Edge mode: acknowledge write clears the flag.
// - Level mode: edge or asserted level sets flag and requests.
// - Level mode: acknowledge clears only when all enabled deasserted.
// - Keeps working in wait mode; enabled pin wakes when enabled.
// - Shallow stop: asynchronous detection wakes the processor.
// - Deep stop disables the unit; it returns in reset state.
// - Background debug mode does not stop detection.
// - Pull resistor is pull-up for polarity zero, pull-down for one.
`ifndef KWU_REGS_VH
`define KWU_REGS_VH

`define KWU_ADDR_W          12
`define KWU_OFF_CTRL        12'h000
`define KWU_OFF_ENABLE      12'h004
`define KWU_OFF_POLARITY    12'h008

`define KWU_BIT_FLAG        3
`define KWU_BIT_ACK         2
`define KWU_BIT_REQ_EN      1
`define KWU_BIT_LEVEL_MODE  0

`define KWU_RST_CTRL        2'h0
`define KWU_RST_ENABLE      8'h00
`define KWU_RST_POLARITY    8'h00

`define KWU_SYNC_STAGES     2

`endif

/* verilog/kwu_sync.v */
/*
 * Two flip-flop synchroniser, one per wake input pin.
 * Assumes the pins are asynchronous to pclk.
 */
`timescale 1ns/100ps
module kwu_sync #(
    parameter WIDTH = 7
) (
    input  wire             pclk,
    input  wire             presetn,
    input  wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);

    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            reg stage1;
            reg stage2;
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    stage1 <= 1'b0;
                    stage2 <= 1'b0;
                end else begin
                    stage1 <= async_in[i];
                    stage2 <= stage1;
                end
            end
            assign sync_out[i] = stage2;
        end
    endgenerate

endmodule // kwu_sync

/* verilog/kwu_detect.v */
/*
 * Per-pin asserted level and edge detection on synchronised samples.
 * Assumes inputs come from flip-flops on pclk.
 */
`timescale 1ns/100ps
module kwu_detect #(
    parameter WIDTH = 7
) (
    input  wire             pclk,
    input  wire             presetn,
    input  wire             clear,
    input  wire [WIDTH-1:0] sample,
    input  wire [WIDTH-1:0] enable,
    input  wire [WIDTH-1:0] polarity,
    output wire [WIDTH-1:0] asserted,
    output wire [WIDTH-1:0] edge_seen
);

    reg [WIDTH-1:0] asserted_prev;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_pin
            // Asserted level follows polarity; disabled pins never assert
            assign asserted[i] = enable[i] &
                (polarity[i] ? sample[i] : ~sample[i]);
            // Deasserted one cycle, asserted the next
            assign edge_seen[i] = asserted[i] &
                                  ~asserted_prev[i];
        end
    endgenerate

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            asserted_prev <= {WIDTH{1'b0}};
        end else if (clear) begin
            asserted_prev <= {WIDTH{1'b0}};
        end else begin
            asserted_prev <= asserted;
        end
    end

endmodule // kwu_detect

/* verification/kwu_pin_model.sv */
/* Key matrix model on the wake pins.
   Assumes pull enables come from the unit. */
`timescale 1ns/100ps
module kwu_pin_model #(
    parameter N = 7
) (
    input  wire         pclk,
    input  wire [N-1:0] pull_up_en,
    input  wire [N-1:0] pull_down_en,
    output wire [N-1:0] wake_input_pin
);
    logic [N-1:0] key = {N{1'b0}};
    logic         tog = 1'b0;
    always @(posedge pclk) begin
        tog <= ~tog;
    end
    // Pressed keys fight the pull; open pins without pull wander
    assign wake_input_pin = (key & pull_down_en)
        | (~key & (pull_up_en | (~pull_down_en & {N{tog}})));
endmodule // kwu_pin_model

/* verification/kwu_keypad_wake_unit_chk.sv */
/* Port checker for the keypad wake unit.
   Assumes one pclk domain; bound at the foot. */
`timescale 1ns/100ps
module kwu_keypad_wake_unit_chk #(
    parameter NUM_PINS = 7
) (
    input wire                pclk,
    input wire                presetn,
    input wire                psel,
    input wire                penable,
    input wire                pwrite,
    input wire [11:0]         paddr,
    input wire [31:0]         pwdata,
    input wire [31:0]         prdata,
    input wire                wait_mode,
    input wire                shallow_stop,
    input wire                deep_stop,
    input wire                irq,
    input wire                wake_request,
    input wire [NUM_PINS-1:0] pull_up_en,
    input wire [NUM_PINS-1:0] pull_down_en
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire ctrl_wr = psel & penable & pwrite & (paddr == 12'h000);
    sequence s_ctrl_rd;
        psel && penable && !pwrite && paddr == 12'h000;
    endsequence
    sequence s_deep_clear;
        !wake_request ##1 (!irq && pull_down_en == {NUM_PINS{1'b0}});
    endsequence
    a_ctrl_unused: assert property (
        s_ctrl_rd |-> prdata[7:4] == 4'h0)
        else $error("ctrl high bits set");
    a_ack_reads_zero: assert property (s_ctrl_rd |-> !prdata[2])
        else $error("ack bit read one");
    a_irq_gated: assert property (s_ctrl_rd ##0 !prdata[1] |-> !irq)
        else $error("irq without enable");
    a_irq_holds: assert property (
        irq && !ctrl_wr && !deep_stop |=> irq)
        else $error("irq dropped alone");
    a_irq_masked: assert property (ctrl_wr && !pwdata[1] |=> !irq)
        else $error("irq after mask");
    a_wait_wake: assert property (
        irq && wait_mode && !deep_stop |-> wake_request)
        else $error("no wake in wait");
    a_stop_wake: assert property (
        irq && shallow_stop && !deep_stop |-> wake_request)
        else $error("no wake in stop");
    a_deep_reset: assert property (deep_stop |-> s_deep_clear)
        else $error("deep stop kept state");
    a_pull_split: assert property (
        (pull_up_en & pull_down_en) == {NUM_PINS{1'b0}})
        else $error("pull up and down both on");
endmodule // kwu_keypad_wake_unit_chk
bind kwu_keypad_wake_unit kwu_keypad_wake_unit_chk
    #(.NUM_PINS(NUM_PINS)) u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .wait_mode(wait_mode), .shallow_stop(shallow_stop),
    .deep_stop(deep_stop), .irq(irq), .wake_request(wake_request),
    .pull_up_en(pull_up_en), .pull_down_en(pull_down_en));

/* verification/kwu_keypad_wake_unit_tb.sv */
/* Self-checking bench for the keypad wake unit.
   Assumes the pin model and the bound checker. */
`timescale 1ns/100ps
module kwu_keypad_wake_unit_tb;
    logic        pclk, presetn, psel, penable, pwrite, err;
    logic        wait_mode, shallow_stop, deep_stop;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, irq, wake_request;
    logic [6:0]  pins, ppe, pu, pd;
    int          bad_count, total_checks;
    kwu_keypad_wake_unit uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .wake_input_pin(pins), .port_pull_enable(ppe), .wait_mode(wait_mode),
        .shallow_stop(shallow_stop), .deep_stop(deep_stop), .irq(irq),
        .wake_request(wake_request), .pull_up_en(pu), .pull_down_en(pd));
    kwu_pin_model u_pins (.pclk(pclk), .pull_up_en(pu), .pull_down_en(pd),
        .wake_input_pin(pins));
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    task finish_test;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH %s exp %h got %h", n, e, g);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        @(posedge pclk);
        while (pready !== 1'b1 && i < 16) begin
            @(posedge pclk);
            i++;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (i == 16) begin
            bad_count++;
            finish_test;
        end
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task rdc(input string n, input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(n, e, rd);
    endtask
    task t_regs;
        rdc("ctrl", 12'h000, 32'h0);
        rdc("enable", 12'h004, 32'h0);
        rdc("polarity", 12'h008, 32'h0);
        wr(12'h000, 32'hFFFFFFFF);
        rdc("ctrl", 12'h000, 32'h3);
        wr(12'h008, 32'h55);
        rdc("polarity", 12'h008, 32'h55);
        @(negedge pclk);
        chk("pulldown", 32'h55, {25'h0, pd});
        chk("pullup", 32'h2A, {25'h0, pu});
        @(posedge pclk);
        ppe <= 7'h0F;
        @(negedge pclk);
        chk("pdmask", 32'h05, {25'h0, pd});
        chk("pumask", 32'h0A, {25'h0, pu});
        @(posedge pclk);
        ppe <= 7'h7F;
        rdc("unmapped", 12'h00C, 32'h0);
        chk("slverr", 32'h1, {31'h0, err});
        chk("pready", 32'h1, {31'h0, pready});
        $display("test regs done");
    endtask
    task t_edge;
        wr(12'h000, 32'h0);
        wr(12'h008, 32'h0);
        wr(12'h004, 32'h7E);
        wr(12'h000, 32'h4);
        wr(12'h000, 32'h2);
        u_pins.key <= 7'h01;
        repeat (4) @(posedge pclk);
        rdc("disabled", 12'h000, 32'h2);
        u_pins.key <= 7'h09;
        repeat (4) @(posedge pclk);
        rdc("edge", 12'h000, 32'hA);
        wr(12'h000, 32'h2);
        rdc("flagwr", 12'h000, 32'hA);
        @(negedge pclk);
        chk("irq", 32'h1, {31'h0, irq});
        wr(12'h000, 32'h6);
        rdc("ack", 12'h000, 32'h2);
        u_pins.key <= 7'h0B;
        repeat (4) @(posedge pclk);
        rdc("rearm", 12'h000, 32'h2);
        u_pins.key <= 7'h01;
        repeat (4) @(posedge pclk);
        u_pins.key <= 7'h21;
        repeat (4) @(posedge pclk);
        rdc("second", 12'h000, 32'hA);
        u_pins.key <= 7'h00;
        wr(12'h000, 32'h0);
        wr(12'h008, 32'h7F);
        wr(12'h000, 32'h4);
        wr(12'h000, 32'h2);
        u_pins.key <= 7'h10;
        repeat (4) @(posedge pclk);
        rdc("rising", 12'h000, 32'hA);
        $display("test edge done");
    endtask
    task t_level;
        wr(12'h000, 32'h3);
        u_pins.key <= 7'h04;
        repeat (4) @(posedge pclk);
        wr(12'h000, 32'h7);
        rdc("levelhold", 12'h000, 32'hB);
        // Leave level mode, then ack with the pin still held
        wr(12'h000, 32'h6);
        wr(12'h000, 32'h6);
        rdc("edgeack", 12'h000, 32'h2);
        wr(12'h000, 32'h3);
        rdc("levelset", 12'h000, 32'hB);
        u_pins.key <= 7'h00;
        repeat (4) @(posedge pclk);
        wr(12'h000, 32'h7);
        rdc("levelclr", 12'h000, 32'h3);
        $display("test level done");
    endtask
    task t_modes;
        wr(12'h000, 32'h2);
        shallow_stop <= 1'b1;
        u_pins.key <= 7'h08;
        @(negedge pclk);
        chk("stopwake", 32'h1, {31'h0, wake_request});
        repeat (4) @(posedge pclk);
        @(negedge pclk);
        chk("stopflag", 32'h1, {31'h0, irq});
        @(posedge pclk);
        shallow_stop <= 1'b0;
        wait_mode <= 1'b1;
        repeat (4) @(posedge pclk);
        @(negedge pclk);
        chk("waitwake", 32'h1, {31'h0, wake_request});
        @(posedge pclk);
        wait_mode <= 1'b0;
        deep_stop <= 1'b1;
        repeat (2) @(posedge pclk);
        deep_stop <= 1'b0;
        u_pins.key <= 7'h00;
        rdc("deepctrl", 12'h000, 32'h0);
        rdc("deepen", 12'h004, 32'h0);
        $display("test modes done");
    endtask
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, wait_mode, shallow_stop, deep_stop} = 6'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        ppe = 7'h7F;
        bad_count = 0;
        total_checks = 0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_regs;
        t_edge;
        t_level;
        t_modes;
        finish_test;
    end
endmodule // kwu_keypad_wake_unit_tb
